// file: rtl/dac_pkg.sv
// Purpose: Shared constants and types for the serial DAC command link
// Assumes: 100 MHz system clock on both ends
// Notes: Frame fields sit at the same bit positions in both formats
package dac_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NUM_CH = 12;
	localparam int NUM_ADDR = 4;
	localparam logic [4:0] CS_FRAME_BITS = 5'h10;
	localparam logic [4:0] LD_FRAME_BITS = 5'h0e;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 14;
	localparam int CALL_POS = 13;
	localparam int PROG_POS = 12;
	localparam int CH_MSB = 11;
	localparam int CH_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int CS_OUT_POS = 0;
	localparam int LD_OUT_POS = 13;
	localparam logic [3:0] CH_ALL = 4'h0;
	localparam logic [3:0] CH_OFF = 4'hf;
	localparam logic [3:0] CH_FIRST = 4'h1;
	localparam logic [3:0] CH_LAST = 4'hc;
	localparam logic [3:0] IDX_LAST = 4'hb;
	localparam int PROG_TIME_NS = 7000000;
	localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int TMR_W = 20;
	localparam int SCLK_HALF_NS = 80;
	localparam int LOAD_HIGH_NS = 5000;
	localparam int RECALL_HIGH_NS = 250;
	localparam int STATUS_SETUP_NS = 100;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_HIGH_CYC = (LOAD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECALL_HIGH_CYC = (RECALL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STATUS_SETUP_CYC = (STATUS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SY_SDI = 0;
	localparam int SY_SCLK = 1;
	localparam int SY_SEL = 2;
	localparam int SY_RCL = 3;
	localparam int SY_ROM0 = 4;
	localparam int SY_ROM1 = 5;
	localparam int SY_FMT = 6;
	localparam int SY_W = 7;
	localparam logic [3:0] REG_FRAME = 4'h0;
	localparam logic [3:0] REG_CFG = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;
	localparam logic [3:0] REG_POLL = 4'hc;
	localparam int CFG_FMT = 0;
	localparam int CFG_ROM_LSB = 1;
	localparam int CFG_ROM_MSB = 2;
	localparam int CFG_RECALL = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_READY = 1;
	localparam int STAT_RX_LSB = 16;
	typedef enum logic [1:0] {CMD_DIRECT = 2'h0, CMD_WRITE = 2'h1, CMD_CALL = 2'h2, CMD_SPECIAL = 2'h3} cmd_t;
	typedef enum logic [2:0] {S_IDLE = 3'h1, S_PROG = 3'h2, S_RECALL = 3'h4} dev_state_t;
	typedef enum logic [8:0] {H_IDLE = 9'h001, H_SETUP = 9'h002, H_LOW = 9'h004, H_HIGH = 9'h008,
		H_LOAD = 9'h010, H_END = 9'h020, H_PRE = 9'h040, H_POLL = 9'h080, H_PULSE = 9'h100} host_state_t;

	function automatic logic ch_valid(input logic [3:0] ch);
		return (ch >= CH_FIRST) && (ch <= CH_LAST);
	endfunction

	function automatic logic [3:0] ch_index(input logic [3:0] ch);
		return ch - CH_FIRST;
	endfunction
endpackage

// file: rtl/dac_link_if.sv
// Purpose: Serial pins between the controller and the DAC device
// Assumes: Data out is driven at all times; its enable only feeds the bench checks
// Notes: format_select high picks the select-framed format
interface dac_link_if;
	logic serial_clk;
	logic serial_data_in;
	logic select_load_strobe;
	logic eeprom_recall_strobe;
	logic rom_addr_bit0;
	logic rom_addr_bit1;
	logic format_select;
	logic serial_data_out;
	logic serial_data_out_oe;
	modport device_mp (input serial_clk, serial_data_in, select_load_strobe, eeprom_recall_strobe,
		rom_addr_bit0, rom_addr_bit1, format_select, output serial_data_out, serial_data_out_oe);
	modport host_mp (output serial_clk, serial_data_in, select_load_strobe, eeprom_recall_strobe,
		rom_addr_bit0, rom_addr_bit1, format_select, input serial_data_out, serial_data_out_oe);
endinterface

// file: rtl/sync_edge.sv
// Purpose: Two-flop synchroniser with edge detection, per bit
// Assumes: Inputs are asynchronous to sys_clk
// Notes: Edges are taken from the second and third stages only
module sync_edge #(parameter int W = 1) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;
	logic [2:0] arm_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
			arm_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
			arm_q <= {arm_q[1:0], 1'b1};
		end
	end

	assign level = sync_q;
	// Masked until prev_q holds a real sample: idle-high pins would show a false rise after reset
	assign rise = arm_q[2] ? (sync_q & ~prev_q) : '0;
	assign fall = arm_q[2] ? (~sync_q & prev_q) : '0;
endmodule // sync_edge

// file: rtl/dac_device.sv
// Purpose: Command logic of a twelve-channel 8-bit DAC with a nonvolatile store
// Assumes: Link pins are asynchronous; the store is modelled as plain flops
// Notes: Store contents survive reset, as a nonvolatile array would
module dac_device import dac_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	dac_link_if.device_mp link,
	output logic [NUM_CH-1:0][7:0] dac_codes,
	output logic prog_busy
);
	logic [SY_W-1:0] pin_lvl;
	logic [SY_W-1:0] pin_rise;
	logic [SY_W-1:0] pin_fall;
	dev_state_t st_q, st_d;
	logic [15:0] sr_q, sr_d;
	logic [4:0] cnt_q, cnt_d;
	logic sdo_q, sdo_d;
	logic oe_q, oe_d;
	logic stat_q, stat_d;
	logic we_q, we_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [3:0] rc_idx_q, rc_idx_d;
	logic [1:0] rc_addr_q, rc_addr_d;
	logic rc_pin_q, rc_pin_d;
	logic [NUM_CH-1:0][7:0] dac_q, dac_d;
	logic busy_q;
	logic [7:0] mem_q [NUM_ADDR][NUM_CH];
	logic mem_we;
	logic exec;
	logic fmt;
	logic sel;
	logic idle;
	logic [1:0] addr;
	logic [3:0] ch;
	logic [7:0] data;
	cmd_t cmd;
	logic [4:0] frame_len;

	sync_edge #(.W(SY_W)) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.async_in({link.format_select, link.rom_addr_bit1, link.rom_addr_bit0, link.eeprom_recall_strobe,
			link.select_load_strobe, link.serial_clk, link.serial_data_in}),
		.level(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign fmt = pin_lvl[SY_FMT];
	assign sel = pin_lvl[SY_SEL];
	assign idle = (st_q == S_IDLE);
	assign frame_len = fmt ? CS_FRAME_BITS : LD_FRAME_BITS;
	// Load-pulse frames carry no address; the pins stand in
	assign addr = fmt ? sr_q[ADDR_MSB:ADDR_LSB] : {pin_lvl[SY_ROM1], pin_lvl[SY_ROM0]};
	assign ch = sr_q[CH_MSB:CH_LSB];
	assign data = sr_q[DATA_MSB:0];
	assign cmd = cmd_t'({sr_q[CALL_POS], sr_q[PROG_POS]});

	always_comb begin
		st_d = st_q;
		sr_d = sr_q;
		cnt_d = cnt_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		stat_d = stat_q;
		we_d = we_q;
		tmr_d = tmr_q;
		rc_idx_d = rc_idx_q;
		rc_addr_d = rc_addr_q;
		rc_pin_d = rc_pin_q;
		dac_d = dac_q;
		mem_we = 1'b0;
		exec = 1'b0;
		case (st_q)
			S_PROG: begin
				if (tmr_q == '0) begin
					st_d = S_IDLE;
				end else begin
					tmr_d = tmr_q - 1'b1;
				end
			end
			S_RECALL: begin
				dac_d[rc_idx_q] = mem_q[rc_addr_q][rc_idx_q];
				if (rc_idx_q == IDX_LAST) begin
					st_d = S_IDLE;
					if (rc_pin_q) begin
						we_d = 1'b0;
					end
				end else begin
					rc_idx_d = rc_idx_q + 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (fmt) begin
			oe_d = ~sel;
			// Clock level at the select fall picks status or shift mode
			if (pin_fall[SY_SEL]) begin
				stat_d = ~pin_lvl[SY_SCLK];
				cnt_d = '0;
			end
			if (pin_rise[SY_SEL]) begin
				stat_d = 1'b0;
				// A busy device drops the frame it merely forwarded
				exec = ~stat_q && (cnt_q == frame_len) && idle;
			end
			if (!sel && !stat_q) begin
				if (pin_rise[SY_SCLK]) begin
					sr_d = {pin_lvl[SY_SDI], sr_q[15:1]};
					cnt_d = (cnt_q == frame_len) ? cnt_q : cnt_q + 1'b1;
				end
				if (pin_fall[SY_SCLK]) begin
					sdo_d = sr_q[CS_OUT_POS];
				end
			end
			if (stat_q) begin
				sdo_d = idle;
			end
		end else begin
			oe_d = 1'b1;
			if (st_q == S_PROG) begin
				sdo_d = 1'b0;
			end else begin
				if (pin_rise[SY_SCLK]) begin
					sr_d = {sr_q[14:0], pin_lvl[SY_SDI]};
					cnt_d = (cnt_q == frame_len) ? cnt_q : cnt_q + 1'b1;
				end
				if (pin_fall[SY_SCLK]) begin
					sdo_d = sr_q[LD_OUT_POS];
				end
				if (pin_rise[SY_SEL]) begin
					exec = (cnt_q == frame_len) && idle;
					cnt_d = '0;
				end
			end
		end
		// Count left from the other format would never match the new frame length
		if (pin_rise[SY_FMT] || pin_fall[SY_FMT]) begin
			cnt_d = '0;
		end
		if (exec) begin
			case (cmd)
				CMD_DIRECT: begin
					if (ch_valid(ch)) begin
						dac_d[ch_index(ch)] = data;
					end
				end
				CMD_CALL: begin
					if (ch == CH_ALL) begin
						st_d = S_RECALL;
						rc_idx_d = '0;
						rc_addr_d = addr;
						rc_pin_d = 1'b0;
					end else if (ch_valid(ch)) begin
						dac_d[ch_index(ch)] = mem_q[addr][ch_index(ch)];
					end
				end
				CMD_WRITE: begin
					if (we_q && ch_valid(ch)) begin
						mem_we = 1'b1;
						st_d = S_PROG;
						tmr_d = TMR_W'(PROG_CYCLES - 1);
					end
				end
				default: begin
					if (ch == CH_ALL) begin
						we_d = 1'b1;
					end else if (ch == CH_OFF) begin
						we_d = 1'b0;
					end else if (ch_valid(ch)) begin
						// Byte lands where the next clocks shift it out; outputs untouched
						sr_d = {8'h00, mem_q[addr][ch_index(ch)]};
						cnt_d = '0;
					end
				end
			endcase
		end
		if (pin_rise[SY_RCL] && idle) begin
			st_d = S_RECALL;
			rc_idx_d = '0;
			rc_addr_d = {pin_lvl[SY_ROM1], pin_lvl[SY_ROM0]};
			rc_pin_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= S_IDLE;
			sr_q <= '0;
			cnt_q <= '0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			stat_q <= 1'b0;
			we_q <= 1'b0;
			tmr_q <= '0;
			rc_idx_q <= '0;
			rc_addr_q <= '0;
			rc_pin_q <= 1'b0;
			dac_q <= '0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sr_q <= sr_d;
			cnt_q <= cnt_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
			stat_q <= stat_d;
			we_q <= we_d;
			tmr_q <= tmr_d;
			rc_idx_q <= rc_idx_d;
			rc_addr_q <= rc_addr_d;
			rc_pin_q <= rc_pin_d;
			dac_q <= dac_d;
			busy_q <= (st_d != S_IDLE);
		end
	end

	// Store keeps its contents through reset, as a nonvolatile array would
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem_q[addr][ch_index(ch)] <= data;
		end
	end

	assign link.serial_data_out = sdo_q;
	assign link.serial_data_out_oe = oe_q;
	assign dac_codes = dac_q;
	assign prog_busy = busy_q;
endmodule // dac_device

// file: rtl/dac_host.sv
// Purpose: Controller that shifts command frames to the DAC device
// Assumes: Software writes a frame word, then polls the engine busy bit
// Notes: Serial clock is a divided system clock, 160 ns period
module dac_host import dac_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	dac_link_if.host_mp link,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	host_state_t st_q, st_d;
	logic [9:0] tmr_q, tmr_d;
	logic [4:0] bcnt_q, bcnt_d;
	logic [15:0] tx_q, tx_d;
	logic [15:0] rx_q, rx_d;
	logic sclk_q, sclk_d;
	logic sdi_q, sdi_d;
	logic sel_q, sel_d;
	logic rcl_q, rcl_d;
	logic fmt_q, fmt_d;
	logic [1:0] rom_q, rom_d;
	logic ready_q, ready_d;
	logic [31:0] rdata_q, rdata_d;
	logic sdo;
	logic done;

	sync_edge #(.W(1)) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.async_in(link.serial_data_out),
		.level(sdo),
		.rise(),
		.fall()
	);

	assign done = (tmr_q == '0);

	always_comb begin
		st_d = st_q;
		tmr_d = done ? tmr_q : tmr_q - 1'b1;
		bcnt_d = bcnt_q;
		tx_d = tx_q;
		rx_d = rx_q;
		sclk_d = sclk_q;
		sdi_d = sdi_q;
		sel_d = sel_q;
		rcl_d = rcl_q;
		fmt_d = fmt_q;
		rom_d = rom_q;
		ready_d = ready_q;
		rdata_d = '0;
		if (reg_rd) begin
			if (reg_addr == REG_CFG) begin
				rdata_d[CFG_FMT] = fmt_q;
				rdata_d[CFG_ROM_MSB:CFG_ROM_LSB] = rom_q;
			end else if (reg_addr == REG_STAT) begin
				rdata_d[STAT_BUSY] = (st_q != H_IDLE);
				rdata_d[STAT_READY] = ready_q;
				rdata_d[STAT_RX_LSB +: 16] = rx_q;
			end
		end
		case (st_q)
			H_IDLE: begin
				sel_d = fmt_q;
				sclk_d = fmt_q;
				if (reg_wr && reg_addr == REG_FRAME) begin
					tx_d = reg_wdata[15:0];
					bcnt_d = fmt_q ? CS_FRAME_BITS : LD_FRAME_BITS;
					sel_d = 1'b0;
					st_d = H_SETUP;
					tmr_d = 10'(SCLK_HALF_CYC - 1);
				end else if (reg_wr && reg_addr == REG_CFG) begin
					fmt_d = reg_wdata[CFG_FMT];
					rom_d = reg_wdata[CFG_ROM_MSB:CFG_ROM_LSB];
					if (reg_wdata[CFG_RECALL]) begin
						rcl_d = 1'b1;
						st_d = H_PULSE;
						tmr_d = 10'(RECALL_HIGH_CYC - 1);
					end
				end else if (reg_wr && reg_addr == REG_POLL) begin
					// Clock goes low first so the select fall means status
					sclk_d = 1'b0;
					st_d = H_PRE;
					tmr_d = 10'(SCLK_HALF_CYC - 1);
				end
			end
			H_SETUP, H_HIGH: begin
				if (done && st_q == H_HIGH && bcnt_q == '0) begin
					if (fmt_q) begin
						sel_d = 1'b1;
						st_d = H_END;
						tmr_d = 10'(SCLK_HALF_CYC - 1);
					end else begin
						sclk_d = 1'b0;
						sel_d = 1'b1;
						st_d = H_LOAD;
						tmr_d = 10'(LOAD_HIGH_CYC - 1);
					end
				end else if (done) begin
					sclk_d = 1'b0;
					sdi_d = fmt_q ? tx_q[CS_OUT_POS] : tx_q[LD_OUT_POS];
					st_d = H_LOW;
					tmr_d = 10'(SCLK_HALF_CYC - 1);
				end
			end
			H_LOW: begin
				if (done) begin
					sclk_d = 1'b1;
					// Read data is taken on the rise after the device moved it
					rx_d = fmt_q ? {sdo, rx_q[15:1]} : {rx_q[14:0], sdo};
					tx_d = fmt_q ? {1'b0, tx_q[15:1]} : {tx_q[14:0], 1'b0};
					bcnt_d = bcnt_q - 1'b1;
					st_d = H_HIGH;
					tmr_d = 10'(SCLK_HALF_CYC - 1);
				end
			end
			H_LOAD: begin
				if (done) begin
					sel_d = 1'b0;
					st_d = H_IDLE;
				end
			end
			H_PRE: begin
				if (done) begin
					sel_d = 1'b0;
					st_d = H_POLL;
					tmr_d = 10'(STATUS_SETUP_CYC - 1);
				end
			end
			H_POLL: begin
				if (done) begin
					ready_d = sdo;
					sel_d = fmt_q;
					sclk_d = fmt_q;
					st_d = H_END;
					tmr_d = 10'(SCLK_HALF_CYC - 1);
				end
			end
			H_PULSE: begin
				if (done) begin
					rcl_d = 1'b0;
					st_d = H_IDLE;
				end
			end
			default: begin
				if (done) begin
					st_d = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= H_IDLE;
			tmr_q <= '0;
			bcnt_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			sclk_q <= 1'b1;
			sdi_q <= 1'b0;
			sel_q <= 1'b1;
			rcl_q <= 1'b0;
			fmt_q <= 1'b1;
			rom_q <= '0;
			ready_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			bcnt_q <= bcnt_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			sclk_q <= sclk_d;
			sdi_q <= sdi_d;
			sel_q <= sel_d;
			rcl_q <= rcl_d;
			fmt_q <= fmt_d;
			rom_q <= rom_d;
			ready_q <= ready_d;
			rdata_q <= rdata_d;
		end
	end

	assign link.serial_clk = sclk_q;
	assign link.serial_data_in = sdi_q;
	assign link.select_load_strobe = sel_q;
	assign link.eeprom_recall_strobe = rcl_q;
	assign link.format_select = fmt_q;
	assign link.rom_addr_bit0 = rom_q[0];
	assign link.rom_addr_bit1 = rom_q[1];
	assign reg_rdata = rdata_q;
endmodule // dac_host

// file: sim/dac_link_asserts.sv
// Purpose: Timing checks on the serial link between controller and device
// Assumes: All pins sampled on sys_clk; device sync delay about 3 cycles
// Notes: Bit counter clears while select is high or on each load rise
module dac_link_asserts import dac_pkg::*; #(
	parameter int unsigned PROG_CYCLES = 50
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic serial_clk,
	input wire logic select_load_strobe,
	input wire logic eeprom_recall_strobe,
	input wire logic format_select,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	input wire logic [NUM_CH-1:0][7:0] dac_codes,
	input wire logic prog_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [4:0] bits_q, bits_d;
	logic [19:0] busy_q, busy_d;
	logic clk_p_q, sel_p_q;
	always_comb begin
		bits_d = bits_q;
		if (serial_clk && !clk_p_q && bits_q != 5'h1f)
			bits_d = bits_q + 5'h01;
		if (format_select ? select_load_strobe : (select_load_strobe && !sel_p_q))
			bits_d = 5'h00;
		busy_d = prog_busy ? busy_q + 20'h00001 : 20'h00000;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bits_q <= 5'h00;
			busy_q <= 20'h00000;
			clk_p_q <= 1'b0;
			sel_p_q <= 1'b0;
		end else begin
			bits_q <= bits_d;
			busy_q <= busy_d;
			clk_p_q <= serial_clk;
			sel_p_q <= select_load_strobe;
		end
	end
	rst_quiet_a: assert property ($rose(rst_b) |-> !serial_data_out_oe && !prog_busy && dac_codes == '0)
		else $error("outputs not quiet after reset");
	cs_oe_off_a: assert property ((format_select && select_load_strobe) [*6] |-> !serial_data_out_oe)
		else $error("data out driven while deselected");
	ld_oe_on_a: assert property ((!format_select) [*6] |-> serial_data_out_oe)
		else $error("data out not driven in load format");
	cs_bits_a: assert property (format_select && $past(format_select) && $rose(select_load_strobe)
		|-> bits_q == 5'h10 || bits_q <= 5'h01)
		else $error("select frame not sixteen bits");
	ld_bits_a: assert property (!format_select && $rose(select_load_strobe) |-> bits_q == 5'h0e)
		else $error("load frame not fourteen bits");
	busy_len_a: assert property (int'(busy_q) <= PROG_CYCLES + 1)
		else $error("busy lasted too long");
	dout_hold_a: assert property ((format_select && !select_load_strobe && serial_clk) [*6]
		|=> $stable(serial_data_out))
		else $error("data out moved while clock high");
	codes_hold_a: assert property ((format_select && !select_load_strobe && !prog_busy && !eeprom_recall_strobe) [*6]
		|=> $stable(dac_codes))
		else $error("codes moved inside a frame");
	recall_busy_a: assert property ($rose(eeprom_recall_strobe) && !prog_busy |-> ##[1:40] prog_busy)
		else $error("recall did not start");
	cover property (format_select && $rose(select_load_strobe) && bits_q == 5'h10);
	cover property (!format_select && $rose(select_load_strobe));
	cover property ($rose(prog_busy));
endmodule // dac_link_asserts

// file: sim/serial_dac_eeprom_command_logic_tb_top.sv
// Purpose: Controller and device joined end to end, driven through registers
// Assumes: Programming shortened to 2000 cycles so a frame can land mid-write
// Notes: Store address 1 holds the values most tests rely on
module serial_dac_eeprom_command_logic_tb_top
	import dac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PROG = 2000;
	logic sys_clk, rst_b, reg_wr, reg_rd, prog_busy;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, s;
	logic [NUM_CH-1:0][7:0] dac_codes, keep;
	int err_count = 0;
	int checks_done = 0;
	dac_link_if link();
	dac_host u_dac_host(.sys_clk, .rst_b, .link(link), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	dac_device #(.PROG_CYCLES(PROG)) u_dac_device(.sys_clk, .rst_b, .link(link), .dac_codes, .prog_busy);
	dac_link_asserts #(.PROG_CYCLES(PROG)) u_dac_link_asserts(.sys_clk, .rst_b, .serial_clk(link.serial_clk),
		.select_load_strobe(link.select_load_strobe), .eeprom_recall_strobe(link.eeprom_recall_strobe),
		.format_select(link.format_select), .serial_data_out(link.serial_data_out),
		.serial_data_out_oe(link.serial_data_out_oe), .dac_codes, .prog_busy);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [NUM_CH*8-1:0] got, input logic [NUM_CH*8-1:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Host engine idle, and device idle too when dev is set
	task automatic idle(input bit dev);
		logic [31:0] t;
		for (int i = 0; i < 5000; i++) begin
			rd(REG_STAT, t);
			if (t[STAT_BUSY] === 1'b0 && (!dev || prog_busy === 1'b0))
				return;
		end
		err_count++;
		$display("Error %0t: wait for idle timed out", $time);
		results();
	endtask
	task automatic send(input logic [1:0] a, input logic c, input logic w, input logic [3:0] ch,
		input logic [7:0] d, input bit dev);
		wr(REG_FRAME, {16'h0000, a, c, w, ch, d});
		idle(dev);
	endtask
	task automatic t_direct();
		send(2'h0, 1'b0, 1'b0, 4'h3, 8'h5a, 1'b1);
		send(2'h0, 1'b0, 1'b0, 4'hc, 8'hff, 1'b1);
		chk(dac_codes[2], 8'h5a, "direct ch3");
		chk(dac_codes[11], 8'hff, "direct ch12");
		$display("test direct done");
	endtask
	task automatic t_write();
		send(2'h1, 1'b1, 1'b1, CH_ALL, 8'h00, 1'b1);
		send(2'h1, 1'b0, 1'b1, 4'h1, 8'h3c, 1'b1);
		send(2'h1, 1'b1, 1'b0, 4'h1, 8'h00, 1'b1);
		chk(dac_codes[0], 8'h3c, "call after write");
		send(2'h0, 1'b1, 1'b1, CH_OFF, 8'h00, 1'b1);
		send(2'h1, 1'b0, 1'b1, 4'h1, 8'h77, 1'b1);
		send(2'h1, 1'b1, 1'b0, 4'h1, 8'h00, 1'b1);
		chk(dac_codes[0], 8'h3c, "write while disabled");
		$display("test write done");
	endtask
	task automatic t_read();
		send(2'h1, 1'b1, 1'b1, 4'h1, 8'h00, 1'b1);
		send(2'h0, 1'b0, 1'b0, CH_ALL, 8'h00, 1'b1);
		rd(REG_STAT, s);
		chk(s[23:16], 8'h3c, "select read");
		$display("test read done");
	endtask
	task automatic t_all();
		send(2'h1, 1'b1, 1'b1, CH_ALL, 8'h00, 1'b1);
		send(2'h1, 1'b0, 1'b1, 4'hc, 8'hc3, 1'b1);
		send(2'h0, 1'b0, 1'b0, 4'h1, 8'h00, 1'b1);
		send(2'h0, 1'b0, 1'b0, 4'hc, 8'h00, 1'b1);
		send(2'h1, 1'b1, 1'b0, CH_ALL, 8'h00, 1'b1);
		chk({dac_codes[11], dac_codes[0]}, 16'hc33c, "all call");
		$display("test all done");
	endtask
	task automatic t_poll();
		send(2'h2, 1'b0, 1'b1, 4'h5, 8'h99, 1'b0);
		wr(REG_POLL, 32'h00000000);
		idle(1'b0);
		rd(REG_STAT, s);
		chk(s[STAT_READY], 1'b0, "busy poll");
		send(2'h0, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
		rd(REG_STAT, s);
		chk(s[31:16], 16'h9599, "forward while busy");
		idle(1'b1);
		wr(REG_POLL, 32'h00000000);
		idle(1'b0);
		rd(REG_STAT, s);
		chk(s[STAT_READY], 1'b1, "ready poll");
		$display("test poll done");
	endtask
	task automatic t_recall();
		send(2'h0, 1'b0, 1'b0, 4'h1, 8'h00, 1'b1);
		wr(REG_CFG, 32'h0000000b);
		repeat (60) @(posedge sys_clk);
		idle(1'b1);
		chk({dac_codes[11], dac_codes[0]}, 16'hc33c, "recall");
		send(2'h1, 1'b0, 1'b1, 4'h1, 8'h11, 1'b1);
		send(2'h1, 1'b1, 1'b0, 4'h1, 8'h00, 1'b1);
		chk(dac_codes[0], 8'h3c, "enable cleared by recall");
		$display("test recall done");
	endtask
	task automatic t_load();
		wr(REG_CFG, 32'h00000002);
		idle(1'b0);
		send(2'h0, 1'b0, 1'b0, 4'h2, 8'h81, 1'b1);
		chk(dac_codes[1], 8'h81, "load direct");
		send(2'h0, 1'b1, 1'b1, 4'h1, 8'h00, 1'b1);
		keep = dac_codes;
		send(2'h0, 1'b0, 1'b0, CH_ALL, 8'h00, 1'b1);
		rd(REG_STAT, s);
		chk(s[23:16], 8'h3c, "load read");
		chk(dac_codes, keep, "codes after read");
		$display("test load done");
	endtask
	task automatic t_load_busy();
		send(2'h0, 1'b1, 1'b1, CH_ALL, 8'h00, 1'b1);
		send(2'h0, 1'b0, 1'b1, 4'h1, 8'h22, 1'b0);
		send(2'h0, 1'b0, 1'b0, 4'h2, 8'h44, 1'b1);
		chk(dac_codes[1], 8'h81, "frame while programming");
		send(2'h0, 1'b1, 1'b0, 4'h1, 8'h00, 1'b1);
		chk(dac_codes[0], 8'h22, "load write landed");
		$display("test load busy done");
	endtask
	initial begin
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_direct();
		t_write();
		t_read();
		t_all();
		t_poll();
		t_recall();
		t_load();
		t_load_busy();
		results();
	end
endmodule // serial_dac_eeprom_command_logic_tb_top
